//--- logic/cpu_regs_regs.vh
// register offsets, field positions, reset values and encodings
`ifndef CPU_REGS_REGS_VH
`define CPU_REGS_REGS_VH

// avalon byte offsets of the dedicated registers
`define OFF_INSTRUCTION_POINTER 6'h00
`define OFF_WORK_REGISTER       6'h04
`define OFF_HOLDING_REG         6'h08
`define OFF_INDEX_REG           6'h0c
`define OFF_EXTRA_POINTER       6'h10
`define OFF_STACK_POINTER       6'h14
`define OFF_PROGRAM_STATUS      6'h18
`define OFF_GPR_PROBE           6'h1c
`define OFF_CORE_STATUS         6'h20

// register file indexes
`define IDX_IP    3'h0
`define IDX_WORK  3'h1
`define IDX_HOLD  3'h2
`define IDX_INDEX 3'h3
`define IDX_EXTRA 3'h4
`define IDX_STACK 3'h5
`define IDX_PS    3'h6
`define NUM_REGS  7

// condition code byte bit positions
`define CC_HALF  7
`define CC_IEN   6
`define CC_IL1   5
`define CC_IL0   4
`define CC_NEG   3
`define CC_ZERO  2
`define CC_OVF   1
`define CC_CARRY 0

// reset values
`define RST_REG   16'h0000
`define RST_PS    16'h0030

// alu operation codes
`define ALU_ADD 3'h0
`define ALU_SUB 3'h1
`define ALU_AND 3'h2
`define ALU_OR  3'h3
`define ALU_XOR 3'h4
`define ALU_SHL 3'h5
`define ALU_SHR 3'h6

// address space layout
`define IO_LAST   16'h007f
`define PROG_BASE 16'h4000
`define GPR_BASE  16'h0100
`define REGION_IO   2'h0
`define REGION_DATA 2'h1
`define REGION_PROG 2'h2

`endif

//--- logic/alu_flags.v
// arithmetic unit that forms results and condition flags
`timescale 1ns/10ps
`default_nettype none

`include "cpu_regs_regs.vh"

module alu_flags (
  input  wire [15:0] a,        // working register operand
  input  wire [15:0] b,        // holding register operand
  input  wire [2:0]  op,       // operation code
  input  wire        byte_op,  // 8-bit instruction
  input  wire        h_in,     // current half carry
  input  wire        c_in,     // current carry
  output reg  [15:0] result,   // operation result
  output reg         h_out,    // half carry
  output reg         n_out,    // negative
  output reg         z_out,    // zero
  output reg         v_out,    // two's complement overflow
  output reg         c_out     // carry, borrow or shifted-out bit
);

  wire [15:0] am  = byte_op ? {8'h00, a[7:0]} : a; // only low byte in 8-bit
  wire [15:0] bm  = byte_op ? {8'h00, b[7:0]} : b;
  wire [16:0] sum = {1'b0, am} + {1'b0, bm};
  wire [16:0] dif = {1'b0, am} - {1'b0, bm};
  reg         am_msb;
  reg         bm_msb;
  reg         r_msb;

  // result, then flags from the result
  always @* begin
    result = 16'h0000;
    h_out  = h_in;
    c_out  = c_in;
    v_out  = 1'b0;
    am_msb = byte_op ? am[7] : am[15];
    bm_msb = byte_op ? bm[7] : bm[15];
    case (op)
      `ALU_ADD: begin
        result = sum[15:0];
        h_out  = am[4] ^ bm[4] ^ sum[4];
        c_out  = byte_op ? sum[8] : sum[16];
      end
      `ALU_SUB: begin
        result = dif[15:0];
        h_out  = am[4] ^ bm[4] ^ dif[4];
        c_out  = byte_op ? (am[7:0] < bm[7:0]) : dif[16];
      end
      `ALU_AND: result = am & bm;
      `ALU_OR:  result = am | bm;
      `ALU_XOR: result = am ^ bm;
      `ALU_SHL: begin
        result = {am[14:0], 1'b0};
        c_out  = am_msb;
      end
      `ALU_SHR: begin
        result = {1'b0, am[15:1]};
        c_out  = am[0];
      end
      default: result = am;
    endcase
    if (byte_op)
      result = {8'h00, result[7:0]};
    r_msb = byte_op ? result[7] : result[15];
    // overflow only for add and subtract
    if (op == `ALU_ADD)
      v_out = (am_msb == bm_msb) && (r_msb != am_msb);
    else if (op == `ALU_SUB)
      v_out = (am_msb != bm_msb) && (r_msb != am_msb);
    n_out = r_msb;
    z_out = byte_op ? (result[7:0] == 8'h00)
                    : (result == 16'h0000);
  end

endmodule // alu_flags

`default_nettype wire

//--- logic/cpu_regs.v
// dedicated cpu registers, program status and avalon access
`timescale 1ns/10ps
`default_nettype none

`include "cpu_regs_regs.vh"

module cpu_regs (
  input  wire        clk,                 // cpu clock
  input  wire        rst,                 // asynchronous reset
  // avalon-mm slave
  input  wire [5:0]  avs_address,         // byte address
  input  wire [3:0]  avs_byteenable,      // byte lanes
  input  wire        avs_read,            // read request
  input  wire        avs_write,           // write request
  input  wire [31:0] avs_writedata,       // write data
  output reg  [31:0] avs_readdata,        // read data
  output wire        avs_waitrequest,     // stall
  // execution datapath
  input  wire        dp_wr_en,            // load a register
  input  wire [2:0]  dp_wr_sel,           // register index
  input  wire [15:0] dp_wr_data,          // load value
  input  wire        ip_inc,              // step the fetch address
  input  wire        alu_go,              // run one alu operation
  input  wire [2:0]  alu_op,              // operation code
  input  wire        alu_byte,            // 8-bit operation
  input  wire [2:0]  gpr_num,             // general register number
  input  wire        irq_req,             // interrupt request
  input  wire [1:0]  irq_level,           // request level code
  output wire [15:0] instruction_pointer, // fetch address
  output wire [15:0] work_register,       // working register
  output wire [15:0] holding_reg,         // partner operand
  output wire [15:0] index_reg,           // index
  output wire [15:0] extra_pointer,       // memory pointer
  output wire [15:0] stack_pointer,       // stack pointer
  output wire [15:0] program_status,      // status word
  output reg  [15:0] gpr_addr,            // general register address
  output reg  [1:0]  fetch_region,        // area of fetch address
  output wire        irq_accept           // request admitted
);

  // slave states, one-hot
  localparam [1:0] ST_IDLE = 2'b01; // waiting for a request
  localparam [1:0] ST_ACK  = 2'b10; // answering

  reg  [15:0] regs [0:`NUM_REGS-1]; // register storage
  reg  [15:0] next_regs [0:`NUM_REGS-1]; // next values
  reg  [1:0]  state;                // slave state
  reg  [1:0]  next_state;           // next slave state
  reg  [2:0]  probe_num;            // register number for the probe
  wire        bus_req;              // any request pending
  wire        bus_wr;               // write takes effect now
  wire [15:0] alu_result;           // alu result
  wire        alu_h;                // alu half carry
  wire        alu_n;                // alu negative
  wire        alu_z;                // alu zero
  wire        alu_v;                // alu overflow
  wire        alu_c;                // alu carry
  wire [7:0]  condition_code_byte;                  // condition code byte
  wire [7:0]  bank_pointer;         // register bank pointer

  // map a 16-bit address to its area of the 64 Kbyte space
  function [1:0] region_of;
    input [15:0] addr;
    begin
      if (addr <= `IO_LAST)
        region_of = `REGION_IO;
      else if (addr < `PROG_BASE)
        region_of = `REGION_DATA;
      else
        region_of = `REGION_PROG;
    end
  endfunction

  // bank pointer and register number to memory address
  function [15:0] gpr_address;
    input [7:0] bank;
    input [2:0] num;
    begin
      gpr_address = `GPR_BASE
                  + {8'h00, bank[4:0], num};
    end
  endfunction

  // byte offset to register index, or all ones if not a register
  function [2:0] reg_index;
    input [5:0] off;
    begin
      case (off)
        `OFF_INSTRUCTION_POINTER: reg_index = `IDX_IP;
        `OFF_WORK_REGISTER:       reg_index = `IDX_WORK;
        `OFF_HOLDING_REG:         reg_index = `IDX_HOLD;
        `OFF_INDEX_REG:           reg_index = `IDX_INDEX;
        `OFF_EXTRA_POINTER:       reg_index = `IDX_EXTRA;
        `OFF_STACK_POINTER:       reg_index = `IDX_STACK;
        `OFF_PROGRAM_STATUS:      reg_index = `IDX_PS;
        default:                  reg_index = 3'h7;
      endcase
    end
  endfunction

  // merge lane-enabled bus data into a 16-bit value
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    begin
      lane_merge = {be[1] ? wd[15:8] : old[15:8],
                    be[0] ? wd[7:0]  : old[7:0]};
    end
  endfunction

  // named views of the storage
  assign instruction_pointer = regs[`IDX_IP];
  assign work_register       = regs[`IDX_WORK];
  assign holding_reg         = regs[`IDX_HOLD];
  assign index_reg           = regs[`IDX_INDEX];
  assign extra_pointer       = regs[`IDX_EXTRA];
  assign stack_pointer       = regs[`IDX_STACK];
  assign program_status      = regs[`IDX_PS];
  assign bank_pointer        = regs[`IDX_PS][15:8];
  assign condition_code_byte                 = regs[`IDX_PS][7:0];

  // flag and result unit
  alu_flags u_alu (
    .a       (regs[`IDX_WORK]),
    .b       (regs[`IDX_HOLD]),
    .op      (alu_op),
    .byte_op (alu_byte),
    .h_in    (condition_code_byte[`CC_HALF]),
    .c_in    (condition_code_byte[`CC_CARRY]),
    .result  (alu_result),
    .h_out   (alu_h),
    .n_out   (alu_n),
    .z_out   (alu_z),
    .v_out   (alu_v),
    .c_out   (alu_c)
  );

  // interrupt admission: enabled and level above the mask level
  function [1:0] level_num;
    input [1:0] code;
    begin
      case (code)
        2'b00:   level_num = 2'h1;
        2'b01:   level_num = 2'h1;
        2'b10:   level_num = 2'h2;
        default: level_num = 2'h3;
      endcase
    end
  endfunction

  assign irq_accept = irq_req && condition_code_byte[`CC_IEN]
                   && (irq_level != 2'b11)
                   && (level_num(irq_level)
                       < level_num({condition_code_byte[`CC_IL1], condition_code_byte[`CC_IL0]}));

  // bus handshake: one wait cycle, answer in the second cycle
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && (state != ST_ACK);
  assign bus_wr          = avs_write && (state == ST_ACK);

  // slave state decode
  always @* begin
    case (state)
      ST_IDLE: next_state = bus_req ? ST_ACK : ST_IDLE;
      ST_ACK:  next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // slave state register
  always @(posedge clk or posedge rst) begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // one update process per register; bus write has priority
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REGS; gi = gi + 1) begin : g_reg
      // next value of this register
      always @* begin
        next_regs[gi] = regs[gi];
        if (bus_wr && reg_index(avs_address) == gi) begin
          // software write through the byte lanes
          next_regs[gi] = lane_merge(regs[gi], avs_writedata[15:0],
                                     avs_byteenable[1:0]);
        end else if (dp_wr_en && dp_wr_sel == gi) begin
          // datapath load
          next_regs[gi] = dp_wr_data;
        end else if (gi == `IDX_WORK && alu_go) begin
          // 8-bit results leave the high byte alone
          if (alu_byte)
            next_regs[gi] = {regs[gi][15:8], alu_result[7:0]};
          else
            next_regs[gi] = alu_result;
        end else if (gi == `IDX_IP && ip_inc) begin
          // advance fetch address, wraps within 64 Kbytes
          next_regs[gi] = regs[gi] + 16'h0001;
        end else if (gi == `IDX_PS && alu_go) begin
          // flag update keeps bank pointer, enable and mask
          next_regs[gi] = {regs[gi][15:8],
                           alu_h,
                           regs[gi][`CC_IEN],
                           regs[gi][`CC_IL1],
                           regs[gi][`CC_IL0],
                           alu_n,
                           alu_z,
                           alu_v,
                           alu_c};
        end
      end

      // storage flip-flops
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          if (gi == `IDX_PS)
            regs[gi] <= `RST_PS;
          else
            regs[gi] <= `RST_REG;
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // probe register number written by software
  always @(posedge clk or posedge rst) begin
    if (rst)
      probe_num <= 3'h0;
    else if (bus_wr && avs_address == `OFF_GPR_PROBE && avs_byteenable[0])
      probe_num <= avs_writedata[2:0];
  end

  // general register address and fetch area follow the next values
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gpr_addr     <= `GPR_BASE;
      fetch_region <= `REGION_IO;
    end else begin
      gpr_addr     <= gpr_address(next_regs[`IDX_PS][15:8],
                                  gpr_num);
      fetch_region <= region_of(next_regs[`IDX_IP]);
    end
  end

  // read data latched in the wait cycle, unmapped reads give zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (state == ST_IDLE && avs_read) begin
      case (avs_address)
        `OFF_GPR_PROBE:
          avs_readdata <= {13'h0000, probe_num,
                           gpr_address(bank_pointer, probe_num)};
        `OFF_CORE_STATUS:
          avs_readdata <= {28'h0000000, irq_accept, 1'b0,
                           region_of(regs[`IDX_IP])};
        default: begin
          if (reg_index(avs_address) != 3'h7)
            avs_readdata <= {16'h0000, regs[reg_index(avs_address)]};
          else
            avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // cpu_regs

`default_nettype wire

//--- tb/cpu_regs_chk.sv
// assertions on the cpu register block ports
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs_regs.vh"
module cpu_regs_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        dp_wr_en,
  input wire logic [2:0]  dp_wr_sel,
  input wire logic [15:0] dp_wr_data,
  input wire logic        ip_inc,
  input wire logic        alu_go,
  input wire logic [2:0]  alu_op,
  input wire logic        alu_byte,
  input wire logic [2:0]  gpr_num,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level,
  input wire logic [15:0] instruction_pointer,
  input wire logic [15:0] work_register,
  input wire logic [15:0] index_reg,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] program_status,
  input wire logic [15:0] gpr_addr,
  input wire logic [1:0]  fetch_region,
  input wire logic        irq_accept
);
  // rank of a level code, 00 and 01 share the top rank
  function automatic logic [1:0] rank(input logic [1:0] c);
    rank = (c == 2'b00) ? 2'b01 : c;
  endfunction
  // area that an address falls in
  function automatic logic [1:0] area(input logic [15:0] a);
    area = (a <= `IO_LAST) ? `REGION_IO :
           (a < `PROG_BASE) ? `REGION_DATA : `REGION_PROG;
  endfunction
  wire       quiet   = !dp_wr_en && !avs_write; // no load overrides
  wire [7:0] work_hi = work_register[15:8];      // upper work byte
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wait_one_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  ip_step_a: assert property (ip_inc && quiet |=>
    instruction_pointer == $past(instruction_pointer) + 16'h0001)
    else $error("fetch address did not step by one");
  index_load_a: assert property (
    dp_wr_en && !avs_write && dp_wr_sel == `IDX_INDEX |=>
    index_reg == $past(dp_wr_data)) else $error("index load lost");
  zero_flag_a: assert property (alu_go && quiet && alu_op != 3'h7 |=>
    program_status[`CC_ZERO] == ($past(alu_byte) ?
    work_register[7:0] == 8'h00 : work_register == 16'h0000))
    else $error("zero flag wrong");
  neg_flag_a: assert property (alu_go && quiet && alu_op != 3'h7 |=>
    program_status[`CC_NEG] == ($past(alu_byte) ? work_register[7]
    : work_register[15])) else $error("negative flag wrong");
  byte_keep_a: assert property (alu_go && quiet && alu_byte |=>
    work_hi == $past(work_hi)) else $error("byte op touched high byte");
  irq_gate_a: assert property (irq_accept == (irq_req &&
    program_status[`CC_IEN] && irq_level != 2'b11 &&
    rank(irq_level) < rank(program_status[5:4])))
    else $error("interrupt admission wrong");
  bank_addr_a: assert property (!$past(rst) |-> gpr_addr ==
    `GPR_BASE + {8'h00, program_status[12:8], $past(gpr_num)})
    else $error("general register address wrong");
  fetch_area_a: assert property (
    fetch_region == area(instruction_pointer))
    else $error("fetch area wrong");
  stack_read_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `OFF_STACK_POINTER && $stable(stack_pointer) |->
    avs_readdata == {16'h0000, stack_pointer})
    else $error("stack pointer read wrong");
  // main scenarios reached
  cover property (alu_go && alu_byte);
  cover property (irq_accept);
  cover property (avs_write && !avs_waitrequest);
endmodule // cpu_regs_chk
bind cpu_regs cpu_regs_chk u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel), .dp_wr_data(dp_wr_data),
  .ip_inc(ip_inc), .alu_go(alu_go), .alu_op(alu_op), .alu_byte(alu_byte),
  .gpr_num(gpr_num), .irq_req(irq_req), .irq_level(irq_level),
  .instruction_pointer(instruction_pointer),
  .work_register(work_register), .index_reg(index_reg),
  .stack_pointer(stack_pointer), .program_status(program_status),
  .gpr_addr(gpr_addr), .fetch_region(fetch_region),
  .irq_accept(irq_accept));
`default_nettype wire

//--- tb/exec_datapath.sv
// execution datapath model driving register loads and alu steps
`timescale 1ns/10ps
`default_nettype none
module exec_datapath (
  input  wire logic        clk,
  output var  logic        dp_wr_en,
  output var  logic [2:0]  dp_wr_sel,
  output var  logic [15:0] dp_wr_data,
  output var  logic        ip_inc,
  output var  logic        alu_go,
  output var  logic [2:0]  alu_op,
  output var  logic        alu_byte
);
  // idle after power up
  initial begin
    dp_wr_en = 1'b0;
    dp_wr_sel = 3'h0;
    dp_wr_data = 16'h0000;
    ip_inc = 1'b0;
    alu_go = 1'b0;
    alu_op = 3'h0;
    alu_byte = 1'b0;
  end
  // one load cycle; released fields show inverted junk
  task load(input logic [2:0] s, input logic [15:0] d);
    dp_wr_en <= 1'b1;
    dp_wr_sel <= s;
    dp_wr_data <= d;
    @(posedge clk);
    dp_wr_en <= 1'b0;
    dp_wr_sel <= ~s;
    dp_wr_data <= ~d;
    @(posedge clk);
  endtask
  // one alu cycle
  task alu(input logic [2:0] op, input logic by);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_byte <= by;
    @(posedge clk);
    alu_go <= 1'b0;
    alu_op <= ~op;
    alu_byte <= ~by;
    @(posedge clk);
  endtask
  // one fetch step
  task step();
    ip_inc <= 1'b1;
    @(posedge clk);
    ip_inc <= 1'b0;
    @(posedge clk);
  endtask
endmodule // exec_datapath
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the cpu register block
`timescale 1ns/10ps
`default_nettype none
`include "cpu_regs_regs.vh"
module testbench;
  typedef struct packed {
    logic [2:0] op; logic by; logic [15:0] a, b, res; logic [4:0] f;
  } alu_row_t;
  // op, byte, work, hold, result, flags h n z v c
  localparam alu_row_t rows [0:11] = '{
    {3'h0, 1'b1, 16'h120f, 16'h0001, 16'h1210, 5'b10000},
    {3'h0, 1'b1, 16'h007f, 16'h0001, 16'h0080, 5'b11010},
    {3'h0, 1'b1, 16'h00ff, 16'h0001, 16'h0000, 5'b10101},
    {3'h1, 1'b1, 16'h0010, 16'h0001, 16'h000f, 5'b10000},
    {3'h1, 1'b1, 16'h0000, 16'h0001, 16'h00ff, 5'b11001},
    {3'h1, 1'b1, 16'h0080, 16'h0001, 16'h007f, 5'b10010},
    {3'h0, 1'b0, 16'h8000, 16'h8000, 16'h0000, 5'b00111},
    {3'h2, 1'b1, 16'h00f0, 16'h000f, 16'h0000, 5'b00100},
    {3'h3, 1'b1, 16'h0080, 16'h0001, 16'h0081, 5'b01000},
    {3'h4, 1'b1, 16'h00aa, 16'h00aa, 16'h0000, 5'b00100},
    {3'h5, 1'b1, 16'h0081, 16'h0000, 16'h0002, 5'b00001},
    {3'h6, 1'b1, 16'h0001, 16'h0000, 16'h0000, 5'b00101}};
  localparam logic [15:0] ipst [0:2] = '{16'h007f, 16'h3fff, 16'hffff};
  localparam logic [1:0]  ipar [0:2] = '{`REGION_DATA, `REGION_PROG,
                                         `REGION_IO};
  logic        clk, rst, avs_read, avs_write, irq_req;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, rd;
  logic [2:0]  gpr_num;
  logic [1:0]  irq_level;
  logic [15:0] v;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, dp_wr_en, ip_inc, alu_go, alu_byte;
  wire  [2:0]  dp_wr_sel, alu_op;
  wire  [15:0] dp_wr_data, gpr_addr;
  wire  [15:0] regs [0:6];
  wire  [1:0]  fetch_region;
  wire         irq_accept;
  integer      fail_count, compares, i;
  cpu_regs u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_byteenable(avs_byteenable), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel), .dp_wr_data(dp_wr_data),
    .ip_inc(ip_inc), .alu_go(alu_go), .alu_op(alu_op),
    .alu_byte(alu_byte), .gpr_num(gpr_num), .irq_req(irq_req),
    .irq_level(irq_level), .instruction_pointer(regs[0]),
    .work_register(regs[1]), .holding_reg(regs[2]), .index_reg(regs[3]),
    .extra_pointer(regs[4]), .stack_pointer(regs[5]),
    .program_status(regs[6]), .gpr_addr(gpr_addr),
    .fetch_region(fetch_region), .irq_accept(irq_accept));
  exec_datapath u_dp (.clk(clk), .dp_wr_en(dp_wr_en),
    .dp_wr_sel(dp_wr_sel), .dp_wr_data(dp_wr_data), .ip_inc(ip_inc),
    .alu_go(alu_go), .alu_op(alu_op), .alu_byte(alu_byte));
  // free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and report
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // avalon write, held until waitrequest is seen low
  task bus_wr(input logic [5:0] a, input logic [3:0] be,
              input logic [15:0] d);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // avalon read, data taken at the answering edge
  task bus_rd(input logic [5:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_byteenable <= 4'hf;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // rank of a level code
  function automatic logic [1:0] rank(input logic [1:0] c);
    rank = (c == 2'b00) ? 2'b01 : c;
  endfunction
  // counts and verdict
  task print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fail_count = fail_count + 1;
    print_verdict();
  end
  // main sequence
  initial begin
    fail_count = 0; compares = 0; rst = 1'b1; avs_read = 1'b0;
    avs_write = 1'b0; avs_address = 6'h00; avs_byteenable = 4'h0;
    avs_writedata = 32'h0; gpr_num = 3'h0; irq_req = 1'b0; irq_level = 2'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 7; i++) check("reset reg", (i == 6) ? `RST_PS : 16'h0, regs[i]);
    for (i = 0; i < 12; i++) begin
      u_dp.load(`IDX_PS, `RST_PS);
      u_dp.load(`IDX_WORK, rows[i].a);
      u_dp.load(`IDX_HOLD, rows[i].b);
      u_dp.alu(rows[i].op, rows[i].by);
      check("alu result", rows[i].res, regs[1]);
      check("alu flags", rows[i].f, {regs[6][7], regs[6][3:0]});
    end
    for (i = 0; i < 7; i++) begin
      v = 16'ha5c3 ^ 16'(i);
      bus_wr(6'(i * 4), 4'h3, v);
      bus_rd(6'(i * 4), rd);
      check("bus reg", {16'h0, v}, rd);
      check("port reg", v, regs[i]);
    end
    bus_wr(`OFF_STACK_POINTER, 4'h1, 16'h00ff);
    check("low lane", 16'ha5ff, regs[5]);
    bus_wr(6'h24, 4'hf, 16'hffff);
    bus_rd(6'h24, rd);
    check("unmapped", 32'h0, rd);
    u_dp.load(`IDX_INDEX, 16'h5a5a);
    check("index load", 16'h5a5a, regs[3]);
    for (i = 0; i < 3; i++) begin
      u_dp.load(`IDX_IP, ipst[i]);
      u_dp.step();
      check("fetch step", 16'(ipst[i] + 16'h1), regs[0]);
      check("fetch area", ipar[i], fetch_region);
    end
    gpr_num <= 3'h7;
    bus_wr(`OFF_PROGRAM_STATUS, 4'h3, 16'h1f30);
    check("bank top", 16'h01ff, gpr_addr);
    gpr_num <= 3'h3;
    bus_wr(`OFF_PROGRAM_STATUS, 4'h3, 16'h2530);
    check("bank wrap", 16'h012b, gpr_addr);
    bus_wr(`OFF_GPR_PROBE, 4'h1, 16'h0005);
    bus_rd(`OFF_GPR_PROBE, rd);
    check("probe", 32'h0005012d, rd);
    for (i = 0; i < 32; i++) begin
      u_dp.load(`IDX_PS, {9'h0, i[4], i[3:2], 4'h0});
      irq_req <= 1'b1;
      irq_level <= i[1:0];
      @(posedge clk);
      check("irq", i[4] && i[1:0] != 2'b11 && rank(i[1:0]) < rank(i[3:2]), irq_accept);
    end
    u_dp.load(`IDX_IP, 16'h4000);
    u_dp.load(`IDX_PS, 16'h0060);
    irq_level <= 2'h0;
    bus_rd(`OFF_CORE_STATUS, rd);
    check("core status", 32'h0000000a, rd);
    irq_req <= 1'b0;
    u_dp.load(`IDX_PS, 16'h1f7f);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("second reset", `RST_PS, regs[6]);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
